// [core/acc_cmp_chan.sv]
// one comparator channel: control register fields, polarity and result latch
`timescale 1ns/1ns
`default_nettype none
module acc_cmp_chan
  import acc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic raw_i,
  input wire logic cycle_end_i,
  output acc_pkg::acc_cmp_cfg_t cfg_o,
  output logic result_o,
  output logic pin_o,
  output logic [7:0] reg_o
);
  import acc_pkg::*;

  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic result_r;
  logic result_nxt;
  logic polar;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_i) begin
      ctrl_nxt = wdata_i & ACC_WMASK_CTRL;
    end
  end

  // off comparator contributes zero: the pin path drops to 0 at once, the result bit reads 0 after the next cycle end
  assign polar = ctrl_r[ACC_ON_BIT] & (raw_i ^ ctrl_r[ACC_INV_BIT]);

  always_comb begin
    result_nxt = result_r;
    if (cycle_end_i) begin
      result_nxt = polar;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= ACC_CTRL_RST;
      result_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      result_r <= result_nxt;
    end
  end

  assign cfg_o = '{on: ctrl_r[ACC_ON_BIT], pin_drive: ctrl_r[ACC_PIN_BIT],
                   invert: ctrl_r[ACC_INV_BIT], speed: ctrl_r[ACC_SPEED_BIT],
                   ref_select: ctrl_r[ACC_REF_BIT], channel: ctrl_r[ACC_CH_LSB +: 2]};
  assign result_o = result_r;
  // pin path bypasses the latch
  assign pin_o = polar;
  assign reg_o = {ctrl_r[7], result_r, ctrl_r[5:0]};
endmodule : acc_cmp_chan
`default_nettype wire

// [core/acc_ctrl.sv]
// top: register bank for the two analog comparators
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module acc_ctrl
  import acc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [8:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic cycle_end_i,
  input wire logic cmp1_raw_i,
  input wire logic cmp2_raw_i,
  input wire logic t1_clk_fall_i,
  output acc_pkg::acc_cmp_cfg_t cmp1_cfg_o,
  output acc_pkg::acc_cmp_cfg_t cmp2_cfg_o,
  output logic [2:0] cmp1_input_o,
  output logic [2:0] cmp2_input_o,
  output logic cmp1_pin_o,
  output logic cmp1_pin_oe_o,
  output logic cmp2_pin_o,
  output logic cmp2_pin_oe_o,
  output logic cmp2_sync_o
);
  import acc_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  acc_bus_req_t req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  function automatic logic [2:0] chan_to_input(input logic [1:0] code);
    chan_to_input = ACC_CH_BASE + {1'b0, code};
  endfunction : chan_to_input

  logic wr1;
  logic wr2;
  logic wr_aux;
  assign wr1 = req.wr && (req.addr == ACC_CMP1_CTRL_OFS);
  assign wr2 = req.wr && (req.addr == ACC_CMP2_CTRL_OFS);
  assign wr_aux = req.wr && (req.addr == ACC_CMP2_AUX_OFS);

  // ----------------------------------------
  // comparator channels
  // ----------------------------------------
  logic res1;
  logic res2;
  logic pin1;
  logic pin2raw;
  logic [7:0] reg1;
  logic [7:0] reg2;

  acc_cmp_chan u_cmp1 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr1),
    .wdata_i(req.wdata),
    .raw_i(cmp1_raw_i),
    .cycle_end_i(cycle_end_i),
    .cfg_o(cmp1_cfg_o),
    .result_o(res1),
    .pin_o(pin1),
    .reg_o(reg1)
  );

  acc_cmp_chan u_cmp2 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr2),
    .wdata_i(req.wdata),
    .raw_i(cmp2_raw_i),
    .cycle_end_i(cycle_end_i),
    .cfg_o(cmp2_cfg_o),
    .result_o(res2),
    .pin_o(pin2raw),
    .reg_o(reg2)
  );

  assign cmp1_input_o = chan_to_input(cmp1_cfg_o.channel);
  assign cmp2_input_o = chan_to_input(cmp2_cfg_o.channel);

  // ----------------------------------------
  // auxiliary register and pin outputs
  // ----------------------------------------
  logic sync_r;
  logic sync_nxt;
  logic pin2_sync_r;
  logic pin2_sync_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb begin
    sync_nxt = sync_r;
    if (wr_aux) begin
      sync_nxt = req.wdata[ACC_SYNC_BIT];
    end
    pin2_sync_nxt = pin2_sync_r;
    if (t1_clk_fall_i) begin
      pin2_sync_nxt = pin2raw;
    end
  end

  assign cmp1_pin_o = pin1;
  assign cmp1_pin_oe_o = cmp1_cfg_o.pin_drive;
  assign cmp2_pin_o = sync_r ? pin2_sync_r : pin2raw;
  assign cmp2_pin_oe_o = cmp2_cfg_o.pin_drive;
  assign cmp2_sync_o = sync_r;

  // ----------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    if (req.rd) begin
      case (req.addr)
        ACC_CMP1_CTRL_OFS: rdata_nxt = reg1;
        ACC_CMP2_CTRL_OFS: rdata_nxt = reg2;
        ACC_CMP2_AUX_OFS: rdata_nxt = {res1, res2, 5'h00, sync_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_r <= 1'b0;
      pin2_sync_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      sync_r <= sync_nxt;
      pin2_sync_r <= pin2_sync_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata_o = rdata_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_enable;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr1 |=> (cmp1_cfg_o.on == $past(wdata_i[7]));
  endproperty
  a_enable: assert property (p_enable) else $error("enable bit not stored");

  property p_result;
    @(posedge clk_i) disable iff (!rst_n_i)
    cycle_end_i |=> (res1 == ($past(cmp1_cfg_o.on) &
                              ($past(cmp1_raw_i) ^ $past(cmp1_cfg_o.invert))));
  endproperty
  a_result: assert property (p_result) else $error("latched result wrong");

  property p_pin;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr1 |=> (cmp1_pin_oe_o == $past(wdata_i[ACC_PIN_BIT]));
  endproperty
  a_pin: assert property (p_pin) else $error("pin enable mismatch");

  property p_invert;
    @(posedge clk_i) disable iff (!rst_n_i)
    cmp1_cfg_o.on |-> (cmp1_pin_o == (cmp1_raw_i ^ cmp1_cfg_o.invert));
  endproperty
  a_invert: assert property (p_invert) else $error("polarity wrong");

  property p_speed;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr1 |=> (cmp1_cfg_o.speed == $past(wdata_i[3]));
  endproperty
  a_speed: assert property (p_speed) else $error("speed bit not stored");

  property p_ref;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr1 |=> (cmp1_cfg_o.ref_select == $past(wdata_i[2]));
  endproperty
  a_ref: assert property (p_ref) else $error("reference bit not stored");

  property p_chan;
    @(posedge clk_i) disable iff (!rst_n_i)
    cmp1_input_o == {1'b1, cmp1_cfg_o.channel};
  endproperty
  a_chan: assert property (p_chan) else $error("channel map wrong");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    !cycle_end_i |=> $stable(res1);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed mid cycle");

  property p_ro;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == ACC_CMP1_CTRL_OFS) |=> (rdata_o[6] == $past(res1));
  endproperty
  a_ro: assert property (p_ro) else $error("result bit not read-only");
endmodule : acc_ctrl
`default_nettype wire

// [shared/acc_pkg.sv]
// package: register map, field positions and types for the comparator control block
package acc_pkg;

  // register offsets (register bus address, 9 bits)
  localparam logic [8:0] ACC_CMP1_CTRL_OFS = 9'h119;
  localparam logic [8:0] ACC_CMP2_CTRL_OFS = 9'h11A;
  localparam logic [8:0] ACC_CMP2_AUX_OFS = 9'h11B;

  // field positions of the main control registers
  localparam int ACC_ON_BIT = 7;
  localparam int ACC_RESULT_BIT = 6;
  localparam int ACC_PIN_BIT = 5;
  localparam int ACC_INV_BIT = 4;
  localparam int ACC_SPEED_BIT = 3;
  localparam int ACC_REF_BIT = 2;
  localparam int ACC_CH_LSB = 0;

  // field positions of the auxiliary register
  localparam int ACC_MIRROR1_BIT = 7;
  localparam int ACC_MIRROR2_BIT = 6;
  localparam int ACC_SYNC_BIT = 0;

  // reset value and write masks
  localparam logic [7:0] ACC_CTRL_RST = 8'h00;
  localparam logic [7:0] ACC_WMASK_CTRL = 8'hBF;
  localparam logic [7:0] ACC_WMASK_AUX = 8'h01;

  // analog input channel numbering: code 0 selects input 4
  localparam logic [2:0] ACC_CH_BASE = 3'h4;

  // register bus request
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acc_bus_req_t;

  // settings one comparator needs from its control register
  typedef struct packed {
    logic on;
    logic pin_drive;
    logic invert;
    logic speed;
    logic ref_select;
    logic [1:0] channel;
  } acc_cmp_cfg_t;

endpackage : acc_pkg

// [testbench/analog_comparator_control_tb.sv]
// testbench: register bank of the two comparators driven through its plain register port
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module analog_comparator_control_tb;
  import acc_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, cycle_end_i = 1'b0;
  logic cmp1_raw_i = 1'b0, cmp2_raw_i = 1'b0, t1_clk_fall_i = 1'b0;
  logic [8:0] addr_i = 9'h000;
  logic [7:0] wdata_i = 8'h00, rdata_o, rd_v, exp8;
  acc_cmp_cfg_t cmp1_cfg_o, cmp2_cfg_o;
  logic [2:0] cmp1_input_o, cmp2_input_o;
  logic cmp1_pin_o, cmp1_pin_oe_o, cmp2_pin_o, cmp2_pin_oe_o, cmp2_sync_o, prev;
  int bad_count = 0;
  int n_compared = 0;

  acc_ctrl i_acc_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cycle_end_i(cycle_end_i),
    .cmp1_raw_i(cmp1_raw_i), .cmp2_raw_i(cmp2_raw_i), .t1_clk_fall_i(t1_clk_fall_i),
    .cmp1_cfg_o(cmp1_cfg_o), .cmp2_cfg_o(cmp2_cfg_o), .cmp1_input_o(cmp1_input_o),
    .cmp2_input_o(cmp2_input_o), .cmp1_pin_o(cmp1_pin_o), .cmp1_pin_oe_o(cmp1_pin_oe_o),
    .cmp2_pin_o(cmp2_pin_o), .cmp2_pin_oe_o(cmp2_pin_oe_o), .cmp2_sync_o(cmp2_sync_o));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // --------------------------------------------------------------------
  // bus tasks
  // --------------------------------------------------------------------
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [8:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    rd_v = rdata_o;
  endtask : rd

  // one-cycle pulse on the timer edge input (t1 set) or the cycle-end input
  task automatic pulse(input bit t1);
    @(posedge clk_i);
    if (t1) begin
      t1_clk_fall_i <= 1'b1;
    end else begin
      cycle_end_i <= 1'b1;
    end
    @(posedge clk_i);
    cycle_end_i <= 1'b0;
    t1_clk_fall_i <= 1'b0;
    #1;
  endtask : pulse

  task automatic end_sim;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(9'h118 + 9'(i));
      `CHK("reset read", 8'h00, rd_v)
    end
    @(posedge clk_i);
    #1;
    `CHK("rdata idle", 8'h00, rdata_o)
    `CHK("input1 reset", 3'h4, cmp1_input_o)
    // result bit and unmapped place must ignore writes
    wr(ACC_CMP1_CTRL_OFS, 8'hFF);
    wr(ACC_CMP2_CTRL_OFS, 8'hFF);
    wr(9'h118, 8'hFF);
    rd(ACC_CMP1_CTRL_OFS);
    `CHK("ctrl1", 8'hBF, rd_v)
    rd(ACC_CMP2_CTRL_OFS);
    `CHK("ctrl2", 8'hBF, rd_v)
    rd(9'h118);
    `CHK("unmapped", 8'h00, rd_v)
    `CHK("cfg1", 7'h7F, cmp1_cfg_o)
    `CHK("cfg2", 7'h7F, cmp2_cfg_o)
    `CHK("input2", 3'h7, cmp2_input_o)
    `CHK("pin2 oe", 1'b1, cmp2_pin_oe_o)
    prev = 1'b0;
    // every polarity, raw level, channel code and pin-drive setting
    for (int k = 0; k < 8; k++) begin
      wr(ACC_CMP1_CTRL_OFS, {1'b1, 1'b0, k[2], k[0], 2'b00, k[2:1]});
      @(posedge clk_i);
      cmp1_raw_i <= k[1];
      cmp2_raw_i <= ~k[1];
      #1;
      `CHK("pin1", k[1] ^ k[0], cmp1_pin_o)
      `CHK("pin2", k[1], cmp2_pin_o)
      `CHK("pin1 oe", k[2], cmp1_pin_oe_o)
      `CHK("input1", {1'b1, k[2:1]}, cmp1_input_o)
      rd(ACC_CMP1_CTRL_OFS);
      `CHK("held result", prev, rd_v[6])
      pulse(1'b0);
      rd(ACC_CMP1_CTRL_OFS);
      `CHK("result1", k[1] ^ k[0], rd_v[6])
      prev = k[1] ^ k[0];
      rd(ACC_CMP2_AUX_OFS);
      exp8 = {prev, k[1], 6'h00};
      `CHK("mirrors", exp8, rd_v)
    end
    wr(ACC_CMP1_CTRL_OFS, 8'h00);
    `CHK("on off", 1'b0, cmp1_cfg_o.on)
    `CHK("cfg1 off", 7'h00, cmp1_cfg_o)
    pulse(1'b0);
    rd(ACC_CMP1_CTRL_OFS);
    `CHK("off read", 8'h00, rd_v)
    // sync keeps comparator two pin until the timer edge pulse
    wr(ACC_CMP2_AUX_OFS, 8'hFF);
    `CHK("sync", 1'b1, cmp2_sync_o)
    rd(ACC_CMP2_AUX_OFS);
    `CHK("aux", 8'h41, rd_v)
    // capture the present pin level (high) before the raw decision moves
    pulse(1'b1);
    @(posedge clk_i);
    cmp2_raw_i <= 1'b1;
    #1;
    `CHK("sync hold", 1'b1, cmp2_pin_o)
    pulse(1'b1);
    @(posedge clk_i);
    #1;
    `CHK("sync take", 1'b0, cmp2_pin_o)
    end_sim();
  end

  // the tests need about 135 cycles; a hang is cut well beyond that
  initial begin
    #(8 * 3000);
    bad_count++;
    end_sim();
  end
endmodule : analog_comparator_control_tb
`default_nettype wire
